// *** verilog/dfc_pkg.sv ***
package dfc_pkg;
  // Pin vector positions at the device
  localparam int P_CS    = 0;
  localparam int P_RW    = 1;
  localparam int P_SCLK  = 2;
  localparam int P_REGISTER_SELECT  = 3;
  localparam int P_SIN   = 4;
  localparam int P_RST   = 5;
  localparam int P_PD    = 6;
  localparam int P_SYNC  = 7;
  localparam int P_HW    = 8;
  localparam int P_CAL   = 9;
  localparam int P_USE   = 10;
  localparam int P_INPUT_CHANNEL_SELECT  = 11;
  localparam int P_DEC0  = 12;
  localparam int P_DEC2  = 14;
  localparam int P_MBIT  = 15;
  localparam int P_MFLT  = 16;
  localparam int PIN_N   = 17;
  localparam logic [PIN_N-1:0] PIN_RST_V = 17'h00003;

  // Configuration field positions
  localparam int CFG_W   = 8;
  localparam int CFG_PD  = 7;
  localparam int CFG_DEC = 2;
  localparam logic [CFG_W-1:0] CFG_RST_V = 8'h00;

  localparam int DATA_W  = 24;
  localparam int STAT_W  = 16;
  localparam int DEC_CW  = 16;
  localparam logic [2:0] DEC_MAX  = 3'h6;
  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [4:0] BIT_SAT  = 5'h1F;
  localparam logic [3:0] WR_LAST  = 4'h7;
  localparam logic [3:0] WR_BITS  = 4'h8;
  localparam logic [1:0] FS_ARMED = 2'h1;
  localparam logic [1:0] FS_NEXT  = 2'h2;

  typedef enum logic [1:0] {
    D_RESET = 2'h0,
    D_IDLE  = 2'h1,
    D_RUN   = 2'h3,
    D_PDOWN = 2'h2
  } dev_state_t;

  // Host register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD  = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_RX   = 8'h0C;
  localparam int CTRL_W    = 10;
  localparam int C_RST     = 0;
  localparam int C_PD      = 1;
  localparam int C_SYNC    = 2;
  localparam int C_HW      = 3;
  localparam int C_CAL     = 4;
  localparam int C_USE     = 5;
  localparam int C_INPUT_CHANNEL_SELECT    = 6;
  localparam int C_DEC0    = 7;
  localparam int C_DEC2    = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST_V = 10'h001;
  localparam int CMD_NB_HI = 4;
  localparam int CMD_READ  = 5;
  localparam int CMD_REGISTER_SELECT  = 6;
  localparam int CMD_WD_LO = 8;
  localparam int CMD_WD_HI = 15;

  localparam int CLK_NS        = 10;
  localparam int SCLK_HALF_NS  = 100;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_SEL   = 3'h3,
    H_HIGH  = 3'h2,
    H_LOW   = 3'h6,
    H_END   = 3'h7
  } host_state_t;
endpackage : dfc_pkg

// *** verilog/dfc_if.sv ***
`timescale 1ns/100ps
interface dfc_if;
  logic       reset_pin;
  logic       power_down_pin;
  logic       sync_pin;
  logic       hw_mode_pin;
  logic       offset_cal_request;
  logic       apply_offset_correction;
  logic       input_channel_select;
  logic       decimation_sel_2;
  logic       decimation_sel_1;
  logic       decimation_sel_0;
  logic       cs_n;
  logic       rd_wr_n;
  logic       sclk;
  logic       register_select;
  logic       serial_in;
  logic       serial_out;
  logic       serial_out_oe;
  logic       data_ready_flag;
  wire        serial_line;

  // Pull-up while the device floats its output
  assign serial_line = serial_out_oe ? serial_out : 1'b1;

  modport dev (
    input  reset_pin, power_down_pin, sync_pin, hw_mode_pin, offset_cal_request,
    input  apply_offset_correction, input_channel_select, decimation_sel_2,
    input  decimation_sel_1, decimation_sel_0, cs_n, rd_wr_n, sclk,
    input  register_select, serial_in,
    output serial_out, serial_out_oe, data_ready_flag
  );
  modport host (
    output reset_pin, power_down_pin, sync_pin, hw_mode_pin, offset_cal_request,
    output apply_offset_correction, input_channel_select, decimation_sel_2,
    output decimation_sel_1, decimation_sel_0, cs_n, rd_wr_n, sclk,
    output register_select, serial_in,
    input  serial_line, data_ready_flag
  );
endinterface : dfc_if

// *** verilog/filter_ctrl.sv ***
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
module filter_ctrl
  import dfc_pkg::*;
#(
  parameter int unsigned DEC_BASE = 256
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  dfc_if.dev                     pins,
  input  wire logic              modulator_bitstream,
  input  wire logic              modulator_fault_in,
  input  wire logic              accum_one_fault,
  input  wire logic              accum_two_fault,
  input  wire logic              cal_done_in,
  input  wire logic [DATA_W-1:0] sample_in,
  input  wire logic              offset_load,
  input  wire logic [DATA_W-1:0] offset_in,
  output logic                   modulator_clk_out,
  output logic                   modulator_sync_out,
  output logic                   filter_bit,
  output logic                   conv_active,
  output logic [DATA_W-1:0]      offset_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [PIN_N-1:0] raw;
  logic [PIN_N-1:0] s1_r;
  logic [PIN_N-1:0] s2_r;
  logic [PIN_N-1:0] s3_r;
  logic [PIN_N-1:0] pin_r;
  logic [PIN_N-1:0] pin_d_r;
  logic [PIN_N-1:0] rise;
  logic [PIN_N-1:0] fall;

  assign raw = {modulator_fault_in, modulator_bitstream, pins.decimation_sel_2,
                pins.decimation_sel_1, pins.decimation_sel_0, pins.input_channel_select,
                pins.apply_offset_correction, pins.offset_cal_request, pins.hw_mode_pin,
                pins.sync_pin, pins.power_down_pin, pins.reset_pin, pins.serial_in,
                pins.register_select, pins.sclk, pins.rd_wr_n, pins.cs_n};

  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r[i]    <= PIN_RST_V[i];
        s2_r[i]    <= PIN_RST_V[i];
        s3_r[i]    <= PIN_RST_V[i];
        pin_r[i]   <= PIN_RST_V[i];
        pin_d_r[i] <= PIN_RST_V[i];
      end else begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
        pin_d_r[i] <= pin_r[i];
      end
    end
  end

  assign rise = pin_r & ~pin_d_r;
  assign fall = ~pin_r & pin_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  dev_state_t       st_r;
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_pins;
  logic [CFG_W-1:0] cfg_eff;
  logic             in_rst;
  logic             pd;
  logic             sync_ev;

  assign cfg_pins = {pin_r[P_PD], pin_r[P_CAL], pin_r[P_USE], pin_r[P_INPUT_CHANNEL_SELECT], 1'b0,
                     pin_r[P_DEC2:P_DEC0]};
  assign cfg_eff  = pin_r[P_HW] ? cfg_pins : cfg_r;
  assign pd       = cfg_eff[CFG_PD];
  assign in_rst   = (st_r == D_RESET);
  assign sync_ev  = rise[P_SYNC] && (st_r == D_IDLE || st_r == D_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= D_RESET;
    end else if (pin_r[P_RST]) begin
      st_r <= D_RESET;
    end else begin
      case (st_r)
        D_RESET: st_r <= D_IDLE;
        D_IDLE: begin
          if (pd) begin
            st_r <= D_PDOWN;
          end else if (sync_ev) begin
            st_r <= D_RUN;
          end
        end
        D_RUN: begin
          if (pd) begin
            st_r <= D_PDOWN;
          end
        end
        D_PDOWN: begin
          if (!pd) begin
            st_r <= D_IDLE;
          end
        end
        default: st_r <= D_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decimation timing
  logic [2:0]        dec_sel;
  logic [DEC_CW-1:0] period_m1;
  logic [DEC_CW-1:0] dec_cnt_r;
  logic              on_period;
  logic              tick;
  logic              realign;

  assign dec_sel   = (cfg_eff[CFG_DEC:0] > DEC_MAX) ? DEC_MAX : cfg_eff[CFG_DEC:0];
  assign period_m1 = DEC_CW'((DEC_BASE << dec_sel) - 1);
  assign on_period = (dec_cnt_r == period_m1);
  assign tick      = (st_r == D_RUN) && on_period && !pd;
  assign realign   = sync_ev && (st_r == D_RUN) && !on_period;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt_r <= '0;
    end else if (st_r != D_RUN || realign || on_period) begin
      dec_cnt_r <= '0;
    end else begin
      dec_cnt_r <= dec_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] sh_r;
  logic [STAT_W-1:0] status_w;
  logic [CFG_W-1:0]  hold_r;
  logic [CFG_W-1:0]  hold_nxt;
  logic [4:0]        bits_r;
  logic [3:0]        wcnt_r;
  logic              rd_act_r;
  logic              wr_act_r;
  logic              is_stat_r;
  logic              fell_r;
  logic              sfall;
  logic              lsb_fall;
  logic              stat_clr;
  logic              first_data;
  logic              wr_load;
  logic              ovw_r;
  logic              mflt_r;
  logic              accum_one_fault_r;
  logic              accum_two_fault_r;
  logic              data_ready_flag_r;
  logic              relo_r;
  logic              attempt_r;
  logic              one_sync_r;
  logic              caldone_r;
  logic [1:0]        fs_r;
  logic              load;

  assign status_w   = {ovw_r | mflt_r | accum_one_fault_r | accum_two_fault_r, ovw_r, mflt_r, accum_one_fault_r, accum_two_fault_r,
                       data_ready_flag_r, one_sync_r, caldone_r, cfg_eff};
  assign sfall      = fall[P_SCLK] && !pin_r[P_CS];
  assign lsb_fall   = rd_act_r && !is_stat_r && sfall && bits_r == BIT_LAST;
  assign stat_clr   = rd_act_r && is_stat_r && sfall && !fell_r;
  assign first_data = rd_act_r && !is_stat_r && sfall && !fell_r;
  assign hold_nxt   = {hold_r[CFG_W-2:0], pin_r[P_SIN]};
  assign wr_load    = wr_act_r && ((sfall && wcnt_r == WR_LAST)
                      || (rise[P_CS] && wcnt_r < WR_BITS));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_r  <= 1'b0;
      wr_act_r  <= 1'b0;
      is_stat_r <= 1'b0;
      fell_r    <= 1'b0;
      bits_r    <= '0;
      wcnt_r    <= '0;
      sh_r      <= '0;
      hold_r    <= '0;
    end else if (fall[P_CS]) begin
      rd_act_r  <= pin_r[P_RW];
      wr_act_r  <= !pin_r[P_RW];
      is_stat_r <= pin_r[P_REGISTER_SELECT];
      fell_r    <= 1'b0;
      bits_r    <= '0;
      wcnt_r    <= '0;
      sh_r      <= pin_r[P_REGISTER_SELECT] ? {status_w, {(DATA_W-STAT_W){status_w[0]}}}
                                 : data_r;
    end else if (pin_r[P_CS]) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
    end else if (rd_act_r) begin
      if (sfall) begin
        fell_r <= 1'b1;
        if (bits_r != BIT_SAT) begin
          bits_r <= bits_r + 1'b1;
        end
      end
      if (rise[P_SCLK] && fell_r) begin
        sh_r <= {sh_r[DATA_W-2:0], is_stat_r & sh_r[0]};
      end
    end else if (wr_act_r && sfall && wcnt_r < WR_BITS) begin
      hold_r <= hold_nxt;
      wcnt_r <= wcnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST_V;
    end else if (in_rst) begin
      cfg_r <= cfg_pins;
    end else if (wr_load) begin
      cfg_r <= (sfall && wcnt_r == WR_LAST) ? hold_nxt : hold_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register, data ready and flags
  assign load = tick && !attempt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r     <= '0;
      data_ready_flag_r     <= 1'b0;
      relo_r     <= 1'b0;
      attempt_r  <= 1'b0;
      one_sync_r <= 1'b0;
      caldone_r  <= 1'b0;
      fs_r       <= '0;
    end else if (in_rst) begin
      data_r     <= '0;
      data_ready_flag_r     <= 1'b0;
      relo_r     <= 1'b0;
      attempt_r  <= 1'b0;
      one_sync_r <= 1'b0;
      caldone_r  <= 1'b0;
      fs_r       <= '0;
    end else begin
      relo_r <= 1'b0;
      if (first_data) begin
        attempt_r <= 1'b1;
      end else if (lsb_fall) begin
        attempt_r <= 1'b0;
      end
      if (sync_ev) begin
        fs_r <= FS_ARMED;
      end
      if (sync_ev && st_r == D_IDLE && !data_ready_flag_r) begin
        data_r <= sample_in;
        data_ready_flag_r <= 1'b1;
      end else if (load) begin
        data_r     <= sample_in;
        caldone_r  <= cal_done_in;
        one_sync_r <= (fs_r == FS_NEXT);
        if (fs_r == FS_ARMED) begin
          fs_r <= FS_NEXT;
        end else if (fs_r == FS_NEXT) begin
          fs_r <= '0;
        end
        data_ready_flag_r <= !data_ready_flag_r;
        relo_r <= data_ready_flag_r;
      end else if (relo_r) begin
        data_ready_flag_r <= 1'b1;
      end else if (lsb_fall) begin
        data_ready_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovw_r  <= 1'b0;
      mflt_r <= 1'b0;
      accum_one_fault_r <= 1'b0;
      accum_two_fault_r <= 1'b0;
    end else if (in_rst) begin
      ovw_r  <= 1'b0;
      mflt_r <= 1'b0;
      accum_one_fault_r <= 1'b0;
      accum_two_fault_r <= 1'b0;
    end else begin
      ovw_r  <= (tick && attempt_r) || (ovw_r && !stat_clr);
      mflt_r <= (pin_r[P_MFLT] && !pd) || (mflt_r && !stat_clr);
      accum_one_fault_r <= accum_one_fault || (accum_one_fault_r && !stat_clr);
      accum_two_fault_r <= accum_two_fault || (accum_two_fault_r && !stat_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_value <= '0;
    end else if (in_rst) begin
      offset_value <= '0;
    end else if (offset_load) begin
      offset_value <= offset_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator side and pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulator_clk_out  <= 1'b0;
      modulator_sync_out <= 1'b0;
      filter_bit         <= 1'b0;
      conv_active        <= 1'b0;
    end else begin
      modulator_clk_out  <= (st_r != D_PDOWN) && !pd && !modulator_clk_out;
      modulator_sync_out <= sync_ev && !pd;
      filter_bit         <= pin_r[P_MBIT] && !pd;
      conv_active        <= (st_r == D_RUN) && !pd;
    end
  end

  assign pins.serial_out      = sh_r[DATA_W-1];
  assign pins.serial_out_oe   = rd_act_r;
  assign pins.data_ready_flag = data_ready_flag_r;

endmodule : filter_ctrl

// *** verilog/host_port.sv ***
`timescale 1ns/100ps
module host_port
  import dfc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dfc_if.host              pins
);

  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rxd_r;
  logic [CFG_W-1:0]  txd_r;
  logic [4:0]        nb_r;
  logic [7:0]        tmr_r;
  host_state_t       st_r;
  logic              cs_n_r;
  logic              rw_r;
  logic              register_select_r;
  logic              sclk_r;
  logic              sin_r;
  logic [1:0]        raw;
  logic [1:0]        s1_r;
  logic [1:0]        s2_r;
  logic [1:0]        s3_r;
  logic [1:0]        in_r;
  logic              wr_en;
  logic              busy;

  assign wr_en = psel && penable && pwrite;
  assign busy  = (st_r != H_IDLE);
  assign raw   = {pins.data_ready_flag, pins.serial_line};

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        in_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          in_r[i] <= s3_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST_V;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata[CTRL_W-1:0];
    end
  end

  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = '0;
    case (paddr)
      ADDR_CTRL: prdata = {{(32-CTRL_W){1'b0}}, ctrl_r};
      ADDR_CMD:  prdata = '0;
      ADDR_STAT: prdata = {30'h00000000, in_r[1], busy};
      ADDR_RX:   prdata = {{(32-DATA_W){1'b0}}, rxd_r};
      default:   pslverr = psel && penable;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= H_IDLE;
      tmr_r  <= '0;
      nb_r   <= '0;
      txd_r  <= '0;
      rxd_r  <= '0;
      cs_n_r <= 1'b1;
      rw_r   <= 1'b1;
      register_select_r <= 1'b0;
      sclk_r <= 1'b0;
      sin_r  <= 1'b0;
    end else if (st_r == H_IDLE) begin
      if (wr_en && paddr == ADDR_CMD) begin
        nb_r   <= pwdata[CMD_NB_HI:0];
        rw_r   <= pwdata[CMD_READ];
        register_select_r <= pwdata[CMD_REGISTER_SELECT];
        txd_r  <= pwdata[CMD_WD_HI:CMD_WD_LO];
        rxd_r  <= '0;
        tmr_r  <= SCLK_HALF_CYC - 1'b1;
        st_r   <= H_SETUP;
      end
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - 1'b1;
    end else begin
      tmr_r <= SCLK_HALF_CYC - 1'b1;
      case (st_r)
        H_SETUP: begin
          cs_n_r <= 1'b0;
          st_r   <= H_SEL;
        end
        H_SEL, H_LOW: begin
          if (nb_r == '0) begin
            cs_n_r <= 1'b1;
            st_r   <= H_END;
          end else begin
            sclk_r <= 1'b1;
            sin_r  <= txd_r[CFG_W-1];
            st_r   <= H_HIGH;
          end
        end
        H_HIGH: begin
          sclk_r <= 1'b0;
          rxd_r  <= {rxd_r[DATA_W-2:0], in_r[0]};
          txd_r  <= {txd_r[CFG_W-2:0], 1'b0};
          nb_r   <= nb_r - 1'b1;
          st_r   <= H_LOW;
        end
        H_END:   st_r <= H_IDLE;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign pins.reset_pin               = ctrl_r[C_RST];
  assign pins.power_down_pin          = ctrl_r[C_PD];
  assign pins.sync_pin                = ctrl_r[C_SYNC];
  assign pins.hw_mode_pin             = ctrl_r[C_HW];
  assign pins.offset_cal_request      = ctrl_r[C_CAL];
  assign pins.apply_offset_correction = ctrl_r[C_USE];
  assign pins.input_channel_select    = ctrl_r[C_INPUT_CHANNEL_SELECT];
  assign pins.decimation_sel_0        = ctrl_r[C_DEC0];
  assign pins.decimation_sel_1        = ctrl_r[C_DEC0+1];
  assign pins.decimation_sel_2        = ctrl_r[C_DEC2];
  assign pins.cs_n                    = cs_n_r;
  assign pins.rd_wr_n                 = rw_r;
  assign pins.register_select         = register_select_r;
  assign pins.sclk                    = sclk_r;
  assign pins.serial_in               = sin_r;

endmodule : host_port

// *** sim/dfc_asserts.sv ***
`timescale 1ns/100ps
module dfc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin,
  input wire logic power_down_pin,
  input wire logic sync_pin,
  input wire logic hw_mode_pin,
  input wire logic cs_n,
  input wire logic rd_wr_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic data_ready_flag,
  input wire logic modulator_clk_out,
  input wire logic modulator_sync_out,
  input wire logic filter_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_low_settled; !sclk[*7]; endsequence
  sequence s_pd_held; (power_down_pin && hw_mode_pin)[*6]; endsequence
  a_reset_init: assert property (reset_pin[*8] |-> !data_ready_flag)
    else $error("ready in reset");
  a_sync_ready: assert property ($rose(sync_pin) && !data_ready_flag && !reset_pin |->
    ##[1:16] data_ready_flag) else $error("no ready after sync");
  a_sync_pulse: assert property ($rose(sync_pin) && !reset_pin && !power_down_pin |->
    ##[2:8] modulator_sync_out) else $error("no sync event");
  a_pd_gate: assert property (s_pd_held |-> !modulator_clk_out && !modulator_sync_out)
    else $error("modulator not gated");
  a_pd_bits: assert property (s_pd_held |-> !filter_bit)
    else $error("bitstream not ignored");
  a_pd_exit: assert property ($fell(power_down_pin) && hw_mode_pin ##1
    (!power_down_pin && !reset_pin)[*8] |-> modulator_clk_out != $past(modulator_clk_out))
    else $error("no clock after wake");
  a_read_oe: assert property ($fell(cs_n) && rd_wr_n |-> ##[2:8] serial_out_oe)
    else $error("read not driven");
  a_float_idle: assert property (cs_n[*6] |-> !serial_out_oe)
    else $error("output not floating");
  a_bit_hold: assert property (s_low_settled ##0 serial_out_oe && $past(serial_out_oe, 3)
    |-> $stable(serial_out)) else $error("bit moved with clock low");
endmodule : dfc_asserts

// *** sim/decim_filter_ctrl_serial_port_tb.sv ***
`timescale 1ns/100ps
module decim_filter_ctrl_serial_port_tb;
  import dfc_pkg::*;
  localparam logic [7:0] ADDR_BAD = 8'h10;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mbit = 1'b0;
  logic        quiet = 1'b0;
  logic        modulator_clk_out;
  logic        modulator_sync_out;
  logic        filter_bit;
  logic [23:0] smp = 24'h0;
  logic [31:0] rd_q = 32'h0;
  logic [7:0]  cfg;
  logic [63:0] exp_q[$];
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  dfc_if bus ();
  filter_ctrl #(.DEC_BASE(4)) u_filter_ctrl (.pclk, .presetn, .pins(bus),
    .modulator_bitstream(mbit), .modulator_fault_in(quiet), .accum_one_fault(quiet),
    .accum_two_fault(quiet), .cal_done_in(quiet), .sample_in(smp), .offset_load(quiet),
    .offset_in(smp), .modulator_clk_out, .modulator_sync_out, .filter_bit,
    .conv_active(), .offset_value());
  host_port u_host_port (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .pins(bus));
  dfc_asserts u_dfc_asserts (.pclk, .presetn, .reset_pin(bus.reset_pin),
    .power_down_pin(bus.power_down_pin), .sync_pin(bus.sync_pin),
    .hw_mode_pin(bus.hw_mode_pin), .cs_n(bus.cs_n), .rd_wr_n(bus.rd_wr_n), .sclk(bus.sclk),
    .serial_out(bus.serial_out), .serial_out_oe(bus.serial_out_oe),
    .data_ready_flag(bus.data_ready_flag), .modulator_clk_out, .modulator_sync_out,
    .filter_bit);
  ////////////////////////////////////////
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    mbit <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end
  // Compare each checked read against the oldest note
  always @(posedge pclk) begin
    logic [31:0] v;
    logic [63:0] e;
    if (psel && penable && pready) begin
      rd_q <= prdata;
      if (paddr == ADDR_RX || paddr == ADDR_BAD) begin
        v = (paddr == ADDR_RX) ? prdata : {31'h0, pslverr};
        e = exp_q.pop_front();
        cmp_count++;
        if ((v & e[63:32]) !== e[31:0]) begin
          n_errors++;
          $display("[FAIL] %0t got %h want %h", $time, v, e[31:0]);
        end
      end
    end
  end
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic ctl(input logic [31:0] v, input int n);
    apb(1'b1, ADDR_CTRL, v);
    repeat (n) @(posedge pclk);
  endtask : ctl
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, ADDR_CMD, c);
    do apb(1'b0, ADDR_STAT, 32'h0); while (rd_q[0] !== 1'b0);
  endtask : cmd
  task automatic rd(input logic rs, input logic [4:0] nb, input logic [31:0] e, m);
    cmd({25'h0, rs, 1'b1, nb});
    exp_q.push_back({m, e});
    apb(1'b0, ADDR_RX, 32'h0);
  endtask : rd
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    void'($urandom(32'h7453C9F3));
    smp = 24'($urandom);
    cfg = 8'(($urandom & 32'h30) | 32'h1);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    exp_q.push_back({32'h1, 32'h1});
    apb(1'b0, ADDR_BAD, 32'h0);
    ctl(32'h0, 20);
    ctl(32'h4, 20);
    ctl(32'h0, 20);
    $display("end sync");
    cmd({16'h0, cfg, 8'h08});
    rd(1'b1, 5'd20, {20'h0, cfg, 4'hF}, 32'hFFF);
    rd(1'b0, 5'd28, {8'h0, smp[19:0], 4'h0}, 32'hFFFFFF);
    rd(1'b0, 5'd5, {27'h0, smp[23:19]}, 32'h1F);
    rd(1'b0, 5'd24, {8'h0, smp}, 32'hFFFFFF);
    rd(1'b1, 5'd16, {16'h0, 8'hC0, cfg}, 32'hF8FF);
    $display("end serial");
    ctl(32'h0A, 100);
    rd(1'b1, 5'd16, 32'h80, 32'hF8FF);
    ctl(32'h48, 40);
    rd(1'b1, 5'd16, 32'h10, 32'hFF);
    $display("end power down");
    ctl(32'h41, 20);
    ctl(32'h40, 20);
    rd(1'b1, 5'd16, 32'h10, 32'hFFFF);
    rd(1'b0, 5'd24, 32'h0, 32'hFFFFFF);
    $display("end reset");
    close_out();
  end
endmodule : decim_filter_ctrl_serial_port_tb
